// ==== design/pcm_pkg.sv ====
// Package for the pin control block: pin_control field layout, per-pin reset
// values and write masks, interrupt-configuration encodings.
// Assumes two ports of 32 pins each, all on the single system clock.
package pcm_pkg;

  localparam int PCM_NPORT = 2;
  localparam int PCM_NPIN  = 32;

  // Field positions inside the 32-bit pin_control word.
  localparam int PCM_PULL_DIR_BIT = 0;
  localparam int PCM_PULL_EN_BIT  = 1;
  localparam int PCM_SLEW_BIT     = 2;
  localparam int PCM_FILT_BIT     = 4;
  localparam int PCM_DRIVE_BIT    = 6;
  localparam int PCM_MUX_LSB      = 8;
  localparam int PCM_IRQ_CFG_LSB  = 16;
  localparam int PCM_IRQ_FLAG_BIT = 24;

  // Per-port bit masks, index [port][pin]; port 0 is A, port 1 is B.
  localparam logic [1:0][31:0] PCM_PULL_DIR_RST = {32'hffff_ffff, 32'hffff_fffe};
  localparam logic [1:0][31:0] PCM_PULL_EN_RST  = {32'h0000_0000, 32'h0000_0005};
  localparam logic [1:0][31:0] PCM_DRIVE_WR     = {32'h0000_0003, 32'h0000_3000};
  localparam logic [1:0][31:0] PCM_SLEW_RST     = {32'hfffc_7ffe, 32'hffff_7f3b};
  localparam logic [1:0][31:0] PCM_MUX3         = {32'h0000_0020, 32'h0000_0005};
  localparam logic [1:0][31:0] PCM_FILT_WR      = {32'h0000_0020, 32'h0000_0000};

  localparam logic [2:0] PCM_MUX_RST      = 3'h0;
  localparam logic [2:0] PCM_MUX_ALT3     = 3'h3;
  localparam logic [2:0] PCM_IRQ_CFG_RST  = 3'h0;
  // Interrupt configuration: bit 2 picks interrupt over DMA, bits 1:0 the edge.
  localparam logic [1:0] PCM_EDGE_RISE    = 2'h1;
  localparam logic [1:0] PCM_EDGE_FALL    = 2'h2;
  localparam logic [1:0] PCM_EDGE_BOTH    = 2'h3;

  typedef struct packed {
    logic       pull_direction_sel;
    logic       pull_enable;
    logic       drive_strength_en;
    logic       slew_rate_en;
    logic       passive_filter_en;
    logic [2:0] pin_function_sel;
    logic [2:0] pin_irq_config;
    logic       pin_irq_flag;
  } pcm_cfg_s;

  // Places a pin's fields at their positions in the register word.
  function automatic logic [31:0] pcm_pack(input pcm_cfg_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[PCM_PULL_DIR_BIT]            = c.pull_direction_sel;
    w[PCM_PULL_EN_BIT]             = c.pull_enable;
    w[PCM_SLEW_BIT]                = c.slew_rate_en;
    w[PCM_FILT_BIT]                = c.passive_filter_en;
    w[PCM_DRIVE_BIT]               = c.drive_strength_en;
    w[PCM_MUX_LSB+:3]              = c.pin_function_sel;
    w[PCM_IRQ_CFG_LSB+:3]          = c.pin_irq_config;
    w[PCM_IRQ_FLAG_BIT]            = c.pin_irq_flag;
    return w;
  endfunction

endpackage

// ==== design/pcm_pin_cell.sv ====
// One pin's pin_control register with its edge detector and status flag.
// Assumes the pin input is synchronous to i_clk_sys and writes are one-cycle.
`timescale 1ns/1ps
`default_nettype none
module pcm_pin_cell #(
  parameter logic       PULL_DIR_RST = 1'b1,
  parameter logic       PULL_EN_RST  = 1'b0,
  parameter logic       SLEW_RST     = 1'b1,
  parameter logic       DRIVE_WR     = 1'b0,
  parameter logic       FILT_WR      = 1'b0,
  parameter logic [2:0] MUX_RST      = 3'h0
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_arst_n,
  input  wire logic              i_en,
  input  wire logic              i_wr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_pin,
  output pcm_pkg::pcm_cfg_s      o_cfg,
  output logic                   o_irq,
  output logic                   o_dma
);
  import pcm_pkg::*;

  pcm_cfg_s cfg_q, cfg_d;
  logic     pin_q, pin_d;
  logic     edge_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and next register value. Fixed fields never take write data.
  always_comb begin
    pin_d    = i_en ? i_pin : pin_q;
    unique case (cfg_q.pin_irq_config[1:0])
      PCM_EDGE_RISE: edge_hit = i_pin & ~pin_q;
      PCM_EDGE_FALL: edge_hit = ~i_pin & pin_q;
      PCM_EDGE_BOTH: edge_hit = i_pin ^ pin_q;
      default:       edge_hit = 1'b0;
    endcase
    cfg_d = cfg_q;
    if (i_wr) begin
      cfg_d.pull_enable          = i_wdata[PCM_PULL_EN_BIT];                     // R2
      cfg_d.slew_rate_en         = i_wdata[PCM_SLEW_BIT];                        // R5
      if (DRIVE_WR) cfg_d.drive_strength_en = i_wdata[PCM_DRIVE_BIT];            // R4
      if (FILT_WR) cfg_d.passive_filter_en = i_wdata[PCM_FILT_BIT];              // R7
      cfg_d.pin_function_sel     = {1'b0, i_wdata[PCM_MUX_LSB+:2]};              // R6
      cfg_d.pin_irq_config       = i_wdata[PCM_IRQ_CFG_LSB+:3];
      if (i_wdata[PCM_IRQ_FLAG_BIT]) cfg_d.pin_irq_flag = 1'b0;
    end
    // A new edge in the same cycle as a clear keeps the flag set.
    if (i_en && edge_hit) cfg_d.pin_irq_flag = 1'b1;
    cfg_d.pull_direction_sel = PULL_DIR_RST;                                    // R1 R15
  end

  // Reset values per pin; every control field ends in a defined state.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_q.pull_direction_sel <= PULL_DIR_RST;                                  // R1
      cfg_q.pull_enable        <= PULL_EN_RST;                                   // R2
      cfg_q.drive_strength_en  <= 1'b0;                                          // R3
      cfg_q.slew_rate_en       <= SLEW_RST;                                      // R5
      cfg_q.passive_filter_en  <= 1'b0;                                          // R7
      cfg_q.pin_function_sel   <= MUX_RST;                                       // R6
      cfg_q.pin_irq_config     <= PCM_IRQ_CFG_RST;                               // R8
      cfg_q.pin_irq_flag       <= 1'b0;                                          // R8
      pin_q                    <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      pin_q <= pin_d;
    end
  end

  assign o_cfg = cfg_q;
  assign o_irq = cfg_q.pin_irq_flag & cfg_q.pin_irq_config[2];
  assign o_dma = cfg_q.pin_irq_flag & ~cfg_q.pin_irq_config[2];

endmodule // pcm_pin_cell
`default_nettype wire

// ==== design/pcm_port_ctrl.sv ====
// Pin control for ports A and B: per-pin pin_control registers, the port
// clock gates, one interrupt and one DMA request per port.
// Assumes a single-cycle register port driven by the peripheral bridge.
//
// Functional notes
// R1 - Pull direction reads fixed, one except A0.
// R2 - Pull enable writable, resets one on A0, A2.
// R3 - Drive strength enable clears on reset.
// R4 - Drive strength writable only B0, B1, A12, A13.
// R5 - Slew rate writable, listed pins reset zero.
// R6 - Function select resets 000/011, top bit zero.
// R7 - Passive filter writable only on the NMI pin.
// R8 - Interrupt config and flag clear on reset.
// R9 - Reset pin filter follows reset pin option.
// R10 - One interrupt output per port.
// R11 - One DMA request output per port.
// R12 - Port clock gates clear on any reset.
// R13 - Software enables clock before using port.
// R14 - Software maps each function to one pin.
// R15 - Writes to fixed fields have no effect.
`timescale 1ns/1ps
`default_nettype none
module pcm_port_ctrl (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_arst_n,
  input  wire logic                          i_gate_wr,
  input  wire logic [1:0]                    i_gate_wdata,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  input  wire logic                          i_reg_port,
  input  wire logic [4:0]                    i_reg_pin,
  input  wire logic [31:0]                   i_reg_wdata,
  input  wire logic [1:0][31:0]              i_pin_in,
  input  wire logic                          i_reset_pin_option,
  output logic [31:0]                        o_reg_rdata,
  output logic [1:0]                         o_port_clock_gate,
  output pcm_pkg::pcm_cfg_s [1:0][31:0]      o_pin_cfg,
  output logic                               o_reset_pin_filter_en,
  output logic [1:0]                         o_port_irq,
  output logic [1:0]                         o_port_dma_req
);
  import pcm_pkg::*;

  logic [1:0]        gate_q, gate_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              rpf_q, rpf_d;
  logic [1:0][31:0]  cell_irq, cell_dma;
  logic [1:0]        irq_q, irq_d, dma_q, dma_d;

  ////////////////////////////////////////////////////////////////////////////
  // One cell per pin; writes reach a cell only while its port clock runs.
  for (genvar p = 0; p < PCM_NPORT; p++) begin : g_port
    for (genvar n = 0; n < PCM_NPIN; n++) begin : g_pin
      pcm_pin_cell #(
        .PULL_DIR_RST (PCM_PULL_DIR_RST[p][n]),
        .PULL_EN_RST  (PCM_PULL_EN_RST[p][n]),
        .SLEW_RST     (PCM_SLEW_RST[p][n]),
        .DRIVE_WR     (PCM_DRIVE_WR[p][n]),
        .FILT_WR      (PCM_FILT_WR[p][n]),
        .MUX_RST      (PCM_MUX3[p][n] ? PCM_MUX_ALT3 : PCM_MUX_RST)
      ) u_cell (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_en      (gate_q[p]),
        .i_wr      (i_reg_wr && gate_q[p] && (i_reg_port == 1'(p))
                    && (i_reg_pin == 5'(n))),
        .i_wdata   (i_reg_wdata),
        .i_pin     (i_pin_in[p][n]),
        .o_cfg     (o_pin_cfg[p][n]),
        .o_irq     (cell_irq[p][n]),
        .o_dma     (cell_dma[p][n])
      );
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gates, read data, merged requests and the reset pin filter.
  // Reads of a gated port return zero rather than stale configuration.
  always_comb begin
    gate_d  = i_gate_wr ? i_gate_wdata : gate_q;
    rdata_d = rdata_q;
    if (i_reg_rd) begin
      rdata_d = gate_q[i_reg_port] ? pcm_pack(o_pin_cfg[i_reg_port][i_reg_pin])
                                   : 32'h0000_0000;                            // R13
    end
    for (int p = 0; p < PCM_NPORT; p++) begin
      irq_d[p] = |cell_irq[p];                                                   // R10
      dma_d[p] = |cell_dma[p];                                                   // R11
    end
    rpf_d = i_reset_pin_option;                                                  // R9
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gate_q  <= 2'h0;                                                           // R12
      rdata_q <= 32'h0000_0000;
      irq_q   <= 2'h0;
      dma_q   <= 2'h0;
      rpf_q   <= 1'b0;
    end else begin
      gate_q  <= gate_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
      dma_q   <= dma_d;
      rpf_q   <= rpf_d;
    end
  end

  assign o_reg_rdata           = rdata_q;
  assign o_port_clock_gate     = gate_q;
  assign o_port_irq            = irq_q;
  assign o_port_dma_req        = dma_q;
  assign o_reset_pin_filter_en = rpf_q;

endmodule // pcm_port_ctrl
`default_nettype wire

// ==== design/pcm_pkg_unused_guard.sv ====
// Intentionally left as a package-free marker; holds no code.

// ==== sim/pcm_port_checker.sv ====
// Checker for the pin control block, watching only its top-level ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module pcm_port_checker (
  input wire logic                          i_clk_sys,
  input wire logic                          i_arst_n,
  input wire logic                          i_gate_wr,
  input wire logic [1:0]                    i_gate_wdata,
  input wire logic                          i_reg_wr,
  input wire logic                          i_reg_rd,
  input wire logic                          i_reg_port,
  input wire logic                          i_reset_pin_option,
  input wire logic [31:0]                   o_reg_rdata,
  input wire logic [1:0]                    o_port_clock_gate,
  input wire pcm_pkg::pcm_cfg_s [1:0][31:0] o_pin_cfg,
  input wire logic                          o_reset_pin_filter_en,
  input wire logic [1:0]                    o_port_irq,
  input wire logic [1:0]                    o_port_dma_req
);
  import pcm_pkg::*;
  logic [1:0] irq_src, dma_src;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // Port request terms rebuilt from each pin's flag and its type bit.
  always_comb begin
    irq_src = 2'h0;
    dma_src = 2'h0;
    for (int p = 0; p < 2; p++) begin
      for (int n = 0; n < 32; n++) begin
        irq_src[p] |= o_pin_cfg[p][n].pin_irq_flag & o_pin_cfg[p][n].pin_irq_config[2];
        dma_src[p] |= o_pin_cfg[p][n].pin_irq_flag & ~o_pin_cfg[p][n].pin_irq_config[2];
      end
    end
  end
  // A write aimed at a port whose clock is off.
  sequence s_gated_wr;
    i_reg_wr && !o_port_clock_gate[i_reg_port];
  endsequence
  a_gate_load: assert property (i_gate_wr |=> o_port_clock_gate == $past(i_gate_wdata))
    else $error("clock gate load wrong");
  a_gated_ignore: assert property (s_gated_wr |=>
    o_pin_cfg[$past(i_reg_port)] == $past(o_pin_cfg[i_reg_port]))
    else $error("gated write landed");
  a_filter_follow: assert property (1'b1 |=>
    o_reset_pin_filter_en == $past(i_reset_pin_option))
    else $error("reset pin filter wrong");
  a_irq_merge: assert property (1'b1 |=> o_port_irq == $past(irq_src))
    else $error("port interrupt wrong");
  a_dma_merge: assert property (1'b1 |=> o_port_dma_req == $past(dma_src))
    else $error("port dma request wrong");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved");
  // Fixed fields are checked on every pin; only the listed pins may differ.
  for (genvar p = 0; p < 2; p++) begin : g_p
    for (genvar n = 0; n < 32; n++) begin : g_n
      localparam bit hi_drv = (p == 1 && n < 2) || (p == 0 && (n == 12 || n == 13));
      localparam bit nmi_pin = (p == 1 && n == 5);
      a_pull_dir_fixed: assert property (o_pin_cfg[p][n].pull_direction_sel == (p + n != 0))
        else $error("pull direction moved");
      a_func_msb_zero: assert property (!o_pin_cfg[p][n].pin_function_sel[2])
        else $error("function select top bit set");
      a_drive_fixed: assert property (hi_drv || !o_pin_cfg[p][n].drive_strength_en)
        else $error("drive strength moved");
      a_filter_fixed: assert property (nmi_pin || !o_pin_cfg[p][n].passive_filter_en)
        else $error("passive filter moved");
    end
  end
endmodule // pcm_port_checker
bind pcm_port_ctrl pcm_port_checker u_checker (
  .i_clk_sys             (i_clk_sys),
  .i_arst_n              (i_arst_n),
  .i_gate_wr             (i_gate_wr),
  .i_gate_wdata          (i_gate_wdata),
  .i_reg_wr              (i_reg_wr),
  .i_reg_rd              (i_reg_rd),
  .i_reg_port            (i_reg_port),
  .i_reset_pin_option    (i_reset_pin_option),
  .o_reg_rdata           (o_reg_rdata),
  .o_port_clock_gate     (o_port_clock_gate),
  .o_pin_cfg             (o_pin_cfg),
  .o_reset_pin_filter_en (o_reset_pin_filter_en),
  .o_port_irq            (o_port_irq),
  .o_port_dma_req        (o_port_dma_req)
);
`default_nettype wire

// ==== sim/pcm_pin_partner.sv ====
// Model of the outside world driving the pin input levels.
// Assumes pins change only just after a clock edge, as the block expects.
`timescale 1ns/1ps
`default_nettype none
module pcm_pin_partner (
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  input  wire logic       i_flip,
  input  wire logic [5:0] i_loc,
  output logic [1:0][31:0] o_pin
);
  // One pin flips per request, so each event is a single clean edge.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin <= '0;
    end else if (i_flip) begin
      o_pin[i_loc[5]][i_loc[4:0]] <= ~o_pin[i_loc[5]][i_loc[4:0]];
    end
  end
endmodule // pcm_pin_partner
`default_nettype wire

// ==== sim/tb_pcm_port_ctrl.sv ====
// Self-checking testbench for the pin control block.
// Assumes the checker is bound and the partner model drives the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_pcm_port_ctrl;
  import pcm_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, gate_wr = 1'b0, wr = 1'b0, rd = 1'b0, opt = 1'b0, flip = 1'b0;
  logic [1:0]           gate_wdata = 2'h0;
  logic [5:0]           loc = 6'h00;
  logic [31:0]          wdata = 32'h0, rdata;
  logic [1:0][31:0]     pins;
  logic [1:0]           gates, irq, dma;
  logic                 filt;
  pcm_cfg_s [1:0][31:0] cfg;
  int                   miscompares = 0, check_count = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  pcm_pin_partner u_partner (.i_clk_sys(clk), .i_arst_n(arst_n), .i_flip(flip), .i_loc(loc),
    .o_pin(pins));
  pcm_port_ctrl dut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_gate_wr(gate_wr),
    .i_gate_wdata(gate_wdata), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_port(loc[5]),
    .i_reg_pin(loc[4:0]), .i_reg_wdata(wdata), .i_pin_in(pins), .i_reset_pin_option(opt),
    .o_reg_rdata(rdata), .o_port_clock_gate(gates), .o_pin_cfg(cfg),
    .o_reset_pin_filter_en(filt), .o_port_irq(irq), .o_port_dma_req(dma));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Reset image of one pin, built from the pin lists.
  function automatic logic [31:0] rst_cfg(int p, int n);
    pcm_cfg_s c;
    c = '0;
    c.pull_direction_sel = !(p == 0 && n == 0);
    c.pull_enable = p == 0 && (n == 0 || n == 2);
    c.slew_rate_en = !(p == 0 ? n inside {2, 6, 7, 15} : n inside {0, 15, 16, 17});
    c.pin_function_sel = (p == 0 && (n == 0 || n == 2)) || p * 32 + n == 37 ? 3'h3 : 3'h0;
    return {20'h0, c};
  endfunction
  // Write then read one pin word; the read follows so it sees the new value.
  task automatic access(logic [5:0] l, logic [31:0] d, logic [31:0] exp);
    @(posedge clk);
    wr <= 1'b1;
    loc <= l;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("pin word", rdata, exp);
  endtask
  task automatic set_gate(logic [1:0] g);
    @(posedge clk);
    gate_wr <= 1'b1;
    gate_wdata <= g;
    @(posedge clk);
    gate_wr <= 1'b0;
  endtask
  // Flip a pin and give the flag and the port output time to settle.
  task automatic pulse_pin(logic [3:0] exp);
    @(posedge clk);
    loc <= 6'h03;
    flip <= 1'b1;
    @(posedge clk);
    flip <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("irq and dma", {28'h0, irq, dma}, {28'h0, exp});
  endtask
  task automatic t_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    check("gates", {30'h0, gates}, 32'h0);
    check("reset requests", {28'h0, irq, dma}, 32'h0);
    for (int i = 0; i < 64; i++) begin
      check("reset cfg", {20'h0, cfg[i/32][i%32]}, rst_cfg(i/32, i%32));
    end
    $display("reset test done");
  endtask
  task automatic t_filter();
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      opt <= v[0];
      repeat (2) @(posedge clk);
      #1;
      check("filter", {31'h0, filt}, v);
    end
    $display("filter test done");
  endtask
  // All ones but function bit 9 to every pin: each pin picks its own general-purpose
  // function, so no function lands on two pins. Only writable fields take the ones,
  // and the function select top bit must stay clear.
  task automatic t_write_all();
    logic [31:0] exp;
    set_gate(2'h3);
    for (int i = 0; i < 64; i++) begin
      exp = 32'h0007_0107 ^ {31'h0, i == 0};
      exp[6] = i == 32 || i == 33 || i == 12 || i == 13;
      exp[4] = i == 37;
      access(i[5:0], 32'hffff_fdff, exp);
    end
    $display("write test done");
  endtask
  task automatic t_event();
    pulse_pin(4'h4);
    access(6'h03, 32'h0103_0000, 32'h0003_0001);
    check("irq cleared", {30'h0, irq}, 32'h0);
    pulse_pin(4'h1);
    // Rising only: the rising edge raises the flag, the falling edge must not.
    access(6'h03, 32'h0105_0000, 32'h0005_0001);
    pulse_pin(4'h4);
    access(6'h03, 32'h0105_0000, 32'h0005_0001);
    pulse_pin(4'h0);
    // Falling only: the mirror image of the pair above.
    access(6'h03, 32'h0106_0000, 32'h0006_0001);
    pulse_pin(4'h0);
    pulse_pin(4'h4);
    $display("event test done");
  endtask
  task automatic t_gated();
    set_gate(2'h1);
    access(6'h27, 32'h0, 32'h0);
    check("gated cfg", {31'h0, cfg[1][7].pull_enable}, 32'h1);
    $display("gated test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_filter();
    t_write_all();
    t_event();
    t_gated();
    t_reset();
    tally_and_finish();
  end
  // The run needs well under a thousand cycles; this bound cuts a hang.
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule // tb_pcm_port_ctrl
`default_nettype wire
